// File: design/ocd_pkg.sv
// Constants and shared types for the two output channel clock dividers.
// Assumes one 25 MHz clock and register access over an AHB-Lite slave port.
// Notes on behaviour
// - Duty correction off: divider output stays low for the programmed low count of input cycles.
// - Duty correction off: divider output stays high for the programmed high count of input cycles.
// - Bypass bit set: divider frozen, its input passed straight to its output unless ignore-sync is set.
// - Ignore-sync bit clear: divider obeys chip sync; set: sync is ignored.
// - Force bit sets a static output level, only while ignore-sync is set.
// - Start-high bit picks the level the output starts toggling from.
// - Four-bit phase offset held in the control register.
// - Direct bit clear: divider drives both outputs of its pair.
// - Direct bit set with path 10b routes oscillator; 01b leaves divider path.
// - Direct bit set with path 00b routes external clock input to the pair.
// - Duty correction on when its disable bit is 0, off when 1.
// - Second identical divider at the next three registers serves pair b.
// - First divider serves pair a, through division or the direct route.
package ocd_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [9:0] IDX_DIV0_COUNTS = 10'h190;
    localparam logic [9:0] IDX_DIV0_CONTROL = 10'h191;
    localparam logic [9:0] IDX_DIV0_ROUTING = 10'h192;
    localparam logic [9:0] IDX_DIV1_COUNTS = 10'h193;
    localparam logic [9:0] IDX_DIV1_CONTROL = 10'h194;
    localparam logic [9:0] IDX_DIV1_ROUTING = 10'h195;
    localparam logic [9:0] IDX_PATH_SEL = 10'h1E1;
    localparam logic [9:0] IDX_STATUS = 10'h1F0;
    localparam logic [2:0] NUM_CFG = 3'h6;

    // ==========================================================
    // Field positions
    localparam int LOW_MSB = 7;
    localparam int LOW_LSB = 4;
    localparam int HIGH_MSB = 3;
    localparam int HIGH_LSB = 0;
    localparam int BYPASS_BIT = 7;
    localparam int NOSYNC_BIT = 6;
    localparam int FORCE_BIT = 5;
    localparam int START_BIT = 4;
    localparam int PHASE_MSB = 3;
    localparam int PHASE_LSB = 0;
    localparam int DIRECT_BIT = 1;
    localparam int DCC_OFF_BIT = 0;

    // ==========================================================
    // Reset values and codes
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [1:0] PATH_SEL_RST = 2'h0;
    localparam logic [1:0] PATH_EXT = 2'h0;
    localparam logic [1:0] PATH_NONE = 2'h1;
    localparam logic [1:0] PATH_OSC = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ==========================================================
    // Divider sequencing states
    typedef enum logic [2:0] {
        OCD_PHASE = 3'b001,
        OCD_LOW = 3'b010,
        OCD_HIGH = 3'b100
    } ocd_phase_type;

endpackage

// File: design/ocd_div_if.sv
// Carrier between the register block and one divider core.
// Assumes the register side drives settings and the core returns its level.
`timescale 1ns/1ns
`default_nettype none
interface ocd_div_if;
    logic [7:0] counts;
    logic [7:0] control;
    logic dcc_off;
    logic tick;
    logic sync;
    logic lvl;
    logic phase_wait;
    modport ctrl (output counts, control, dcc_off, tick, sync, input lvl, phase_wait);
    modport div (input counts, control, dcc_off, tick, sync, output lvl, phase_wait);
endinterface
`default_nettype wire

// File: design/ocd_divider.sv
// One programmable channel divider: phase wait, low and high phases.
// Assumes tick marks one rising edge of the divider input clock.
`timescale 1ns/1ns
`default_nettype none
module ocd_divider (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Settings in, divided level out
    ocd_div_if.div dif
);

    typedef struct packed {
        ocd_pkg::ocd_phase_type fsm;
        logic [4:0] cnt;
        logic [3:0] pcnt;
        logic lvl;
    } ocd_div_st_type;

    ocd_div_st_type s_q;
    ocd_div_st_type s_d;
    logic [4:0] lo_raw;
    logic [4:0] hi_raw;
    logic [4:0] total;
    logic [4:0] lo_len;
    logic [4:0] hi_len;
    logic [4:0] cnt_inc;
    logic start_hi;
    logic [3:0] offset;

    // A zero count would stall the phase, so it acts as one cycle
    function automatic logic [4:0] at_least_one(input logic [3:0] f);
        return (f == 4'h0) ? 5'h01 : {1'b0, f};
    endfunction

    function automatic ocd_pkg::ocd_phase_type run_state(input logic hi);
        return hi ? ocd_pkg::OCD_HIGH : ocd_pkg::OCD_LOW;
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        lo_raw = at_least_one(dif.counts[ocd_pkg::LOW_MSB:ocd_pkg::LOW_LSB]);
        hi_raw = at_least_one(dif.counts[ocd_pkg::HIGH_MSB:ocd_pkg::HIGH_LSB]);
        total = lo_raw + hi_raw;
        if (!dif.dcc_off) begin
            // Balanced split; odd periods give the extra cycle to high
            hi_len = 5'((total + 5'h01) >> 1);
            lo_len = total - hi_len;
        end else begin
            hi_len = hi_raw;
            lo_len = lo_raw;
        end
        start_hi = dif.control[ocd_pkg::START_BIT];
        offset = dif.control[ocd_pkg::PHASE_MSB:ocd_pkg::PHASE_LSB];
        cnt_inc = s_q.cnt + 5'h01;
        s_d = s_q;
        if (dif.control[ocd_pkg::BYPASS_BIT]) begin
            s_d = s_q;
        end else if (dif.sync && !dif.control[ocd_pkg::NOSYNC_BIT]) begin
            s_d.lvl = start_hi;
            s_d.cnt = 5'h00;
            s_d.pcnt = offset;
            s_d.fsm = (offset == 4'h0) ? run_state(start_hi) : ocd_pkg::OCD_PHASE;
        end else if (dif.tick) begin
            case (s_q.fsm)
                ocd_pkg::OCD_PHASE: begin
                    if (s_q.pcnt <= 4'h1) begin
                        s_d.pcnt = 4'h0;
                        s_d.fsm = run_state(start_hi);
                    end else begin
                        s_d.pcnt = s_q.pcnt - 4'h1;
                    end
                end
                ocd_pkg::OCD_LOW: begin
                    if (cnt_inc >= lo_len) begin
                        s_d.fsm = ocd_pkg::OCD_HIGH;
                        s_d.cnt = 5'h00;
                        s_d.lvl = 1'b1;
                    end else begin
                        s_d.cnt = cnt_inc;
                    end
                end
                ocd_pkg::OCD_HIGH: begin
                    if (cnt_inc >= hi_len) begin
                        s_d.fsm = ocd_pkg::OCD_LOW;
                        s_d.cnt = 5'h00;
                        s_d.lvl = 1'b0;
                    end else begin
                        s_d.cnt = cnt_inc;
                    end
                end
                default: begin
                    s_d.fsm = ocd_pkg::OCD_PHASE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{fsm: ocd_pkg::OCD_LOW, cnt: 5'h00, pcnt: 4'h0, lvl: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign dif.lvl = s_q.lvl;
    assign dif.phase_wait = (s_q.fsm == ocd_pkg::OCD_PHASE);

endmodule // ocd_divider
`default_nettype wire

// File: design/ocd_top.sv
// Two output channel dividers with their output routing and AHB-Lite registers.
// Assumes oscillator and external clock levels and sync are synchronous to clk.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module ocd_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Clock sources and chip sync
    input wire logic internal_oscillator,
    input wire logic ext_clk_in,
    input wire logic chip_sync,
    // Output pairs
    output logic pair_a_output_first,
    output logic pair_a_output_second,
    output logic pair_b_output_first,
    output logic pair_b_output_second
);

    typedef struct packed {
        logic [5:0][7:0] cfg;
        logic [1:0] path_sel;
        logic dp_wr;
        logic [9:0] dp_idx;
        logic [31:0] rdata;
        logic osc_prev;
        logic ext_prev;
        logic [1:0] pin;
    } ocd_top_st_type;

    ocd_top_st_type s_q;
    ocd_top_st_type s_d;
    ocd_div_if dif0 ();
    ocd_div_if dif1 ();
    logic osc_tick;
    logic ext_tick;
    logic [1:0] div_lvl;
    logic [1:0] div_wait;
    logic [7:0] status;
    logic [9:0] aidx;
    logic mapped;
    logic [2:0] slot;

    // ==========================================================
    // Helpers
    function automatic logic [2:0] cfg_slot(input logic [9:0] idx);
        logic [9:0] off;
        off = idx - ocd_pkg::IDX_DIV0_COUNTS;
        if (idx >= ocd_pkg::IDX_DIV0_COUNTS && idx <= ocd_pkg::IDX_DIV1_ROUTING) begin
            return off[2:0];
        end
        return 3'h7;
    endfunction

    // Divider input follows the path select; only 10b picks the oscillator
    function automatic logic pick_src(input logic [1:0] path, input logic osc,
                                      input logic ext);
        return (path == ocd_pkg::PATH_OSC) ? osc : ext;
    endfunction

    function automatic logic [31:0] read_word(input logic [5:0][7:0] cfg,
                                              input logic [1:0] path,
                                              input logic [7:0] stat,
                                              input logic [9:0] idx);
        logic [2:0] sl;
        sl = cfg_slot(idx);
        if (sl < ocd_pkg::NUM_CFG) begin
            return {24'h00_0000, cfg[sl]};
        end else if (idx == ocd_pkg::IDX_PATH_SEL) begin
            return {30'h0000_0000, path};
        end else if (idx == ocd_pkg::IDX_STATUS) begin
            return {24'h00_0000, stat};
        end
        return 32'h0000_0000;
    endfunction

    // Pin level for one pair, in order of precedence
    function automatic logic pair_level(input logic [7:0] ctrl, input logic [7:0] route,
                                        input logic [1:0] path, input logic osc,
                                        input logic ext, input logic dlvl);
        if (route[ocd_pkg::DIRECT_BIT]
            && (path == ocd_pkg::PATH_OSC || path == ocd_pkg::PATH_EXT)) begin
            return pick_src(path, osc, ext);
        end else if (ctrl[ocd_pkg::NOSYNC_BIT]) begin
            return ctrl[ocd_pkg::FORCE_BIT];
        end else if (ctrl[ocd_pkg::BYPASS_BIT]) begin
            return pick_src(path, osc, ext);
        end
        return dlvl;
    endfunction

    // ==========================================================
    // Divider cores
    assign osc_tick = internal_oscillator & ~s_q.osc_prev;
    assign ext_tick = ext_clk_in & ~s_q.ext_prev;

    assign dif0.counts = s_q.cfg[0];
    assign dif0.control = s_q.cfg[1];
    assign dif0.dcc_off = s_q.cfg[2][ocd_pkg::DCC_OFF_BIT];
    assign dif0.tick = pick_src(s_q.path_sel, osc_tick, ext_tick);
    assign dif0.sync = chip_sync;
    // Same layout three registers on, feeding pair b
    assign dif1.counts = s_q.cfg[3];
    assign dif1.control = s_q.cfg[4];
    assign dif1.dcc_off = s_q.cfg[5][ocd_pkg::DCC_OFF_BIT];
    assign dif1.tick = pick_src(s_q.path_sel, osc_tick, ext_tick);
    assign dif1.sync = chip_sync;

    ocd_divider u_div0 (
        .clk(clk),
        .rst_n(rst_n),
        .dif(dif0.div)
    );

    ocd_divider u_div1 (
        .clk(clk),
        .rst_n(rst_n),
        .dif(dif1.div)
    );

    assign div_lvl = {dif1.lvl, dif0.lvl};
    assign div_wait = {dif1.phase_wait, dif0.phase_wait};
    assign status = {4'h0, div_wait, s_q.pin};

    // ==========================================================
    // Registers, bus and pin routing
    always_comb begin
        s_d = s_q;
        s_d.osc_prev = internal_oscillator;
        s_d.ext_prev = ext_clk_in;
        // Write data phase lands first, so a read right behind sees it
        slot = cfg_slot(s_q.dp_idx);
        if (s_q.dp_wr) begin
            if (slot < ocd_pkg::NUM_CFG) begin
                s_d.cfg[slot] = hwdata[7:0];
            end else if (s_q.dp_idx == ocd_pkg::IDX_PATH_SEL) begin
                s_d.path_sel = hwdata[1:0];
            end
        end
        s_d.dp_wr = 1'b0;
        aidx = haddr[11:2];
        mapped = (haddr[31:12] == 20'h0_0000) && (haddr[1:0] == 2'h0)
            && (hsize == ocd_pkg::HSIZE_WORD);
        if (hsel && htrans[1] && hready) begin
            s_d.dp_wr = hwrite && mapped;
            s_d.dp_idx = aidx;
            if (!hwrite) begin
                s_d.rdata = mapped ? read_word(s_d.cfg, s_d.path_sel, status, aidx)
                                   : 32'h0000_0000;
            end
        end
        // Pair a from divider 0, pair b from divider 1
        s_d.pin[0] = pair_level(s_q.cfg[1], s_q.cfg[2], s_q.path_sel,
                                internal_oscillator, ext_clk_in, div_lvl[0]);
        s_d.pin[1] = pair_level(s_q.cfg[4], s_q.cfg[5], s_q.path_sel,
                                internal_oscillator, ext_clk_in, div_lvl[1]);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{cfg: {6{ocd_pkg::CFG_RST}}, path_sel: ocd_pkg::PATH_SEL_RST,
                     dp_wr: 1'b0, dp_idx: 10'h000, rdata: 32'h0000_0000,
                     osc_prev: 1'b0, ext_prev: 1'b0, pin: 2'h0};
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    assign hrdata = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // Both outputs of a pair carry the same level
    assign pair_a_output_first = s_q.pin[0];
    assign pair_a_output_second = s_q.pin[0];
    assign pair_b_output_first = s_q.pin[1];
    assign pair_b_output_second = s_q.pin[1];

endmodule // ocd_top
`default_nettype wire

// File: verif/ocd_top_sva.sv
// Checker for the divider block: bus answers, paired pins, forced and sync levels.
// Assumes it is bound to ocd_top and shadows divider 0 settings from bus writes.
`timescale 1ns/1ns
`default_nettype none
module ocd_top_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Sync and pins
    input wire logic chip_sync,
    input wire logic pair_a_output_first,
    input wire logic pair_a_output_second,
    input wire logic pair_b_output_first,
    input wire logic pair_b_output_second
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // =========================================================
    // Shadow of divider 0 settings, so pin levels can be predicted
    logic [11:0] wa_q;
    logic [7:0] ctl_q;
    logic [1:0] rte_q;
    logic [1:0] path_q;
    wire logic dir = rte_q[1] && !path_q[0];
    wire logic rd = hsel && htrans[1] && hready && !hwrite;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wa_q <= 12'h000;
            ctl_q <= 8'h00;
            rte_q <= 2'h0;
            path_q <= 2'h0;
        end else begin
            wa_q <= (hsel && htrans[1] && hready && hwrite) ? haddr[11:0] : 12'h000;
            if (wa_q == 12'h644) ctl_q <= hwdata[7:0];
            if (wa_q == 12'h648) rte_q <= hwdata[1:0];
            if (wa_q == 12'h784) path_q <= hwdata[1:0];
        end
    end
    // =========================================================
    // Assertions
    chk_ready_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    chk_read_upper: assert property (rd |=> hrdata[31:8] == 24'h00_0000)
        else $error("read data above the byte not zero");
    chk_unmapped_read: assert property (rd && haddr[31:12] != 20'h0_0000
        |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_hrdata_hold: assert property (!rd |=> $stable(hrdata))
        else $error("read data moved without a read");
    chk_pair_a_same: assert property (pair_a_output_first == pair_a_output_second)
        else $error("pair a outputs differ");
    chk_pair_b_same: assert property (pair_b_output_first == pair_b_output_second)
        else $error("pair b outputs differ");
    // Pin lags a settings write by one clock, so the shadow must have settled first
    chk_force_level: assert property ((ctl_q[6] && !dir && $stable(ctl_q))[*4]
        |-> pair_a_output_first == ctl_q[5])
        else $error("forced level not on pair a");
    chk_sync_start: assert property ((chip_sync && ctl_q[7:6] == 2'h0 && !dir)[*4]
        |-> pair_a_output_first == ctl_q[4])
        else $error("sync did not set start level");
    cover property (chip_sync && ctl_q[7:6] == 2'h0);
    cover property (ctl_q[6] && ctl_q[5]);
    cover property (dir);
endmodule // ocd_top_sva
bind ocd_top ocd_top_sva chk (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .chip_sync, .pair_a_output_first, .pair_a_output_second,
    .pair_b_output_first, .pair_b_output_second);
`default_nettype wire

// File: verif/output_channel_clock_divider_test.sv
// Self-checking bench for the two output channel dividers.
// Assumes ocd_top as the one AHB-Lite slave; hready is fed back from hreadyout.
`timescale 1ns/1ns
`default_nettype none
module output_channel_clock_divider_test;
    logic clk, rst_n, hsel, hwrite, osc, ext, sync, v;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, pa0, pa1, pb0, pb1;
    int num_errors, n_compared, t0, t1, h, l;
    localparam logic [31:0] BASE = {20'h0_0000, ocd_pkg::IDX_DIV0_COUNTS, 2'b00};
    localparam logic [31:0] PSEL = {20'h0_0000, ocd_pkg::IDX_PATH_SEL, 2'b00};
    localparam logic [31:0] STAT = {20'h0_0000, ocd_pkg::IDX_STATUS, 2'b00};
    // Rows: control, routing, path, toggles in 10 clocks, level (F = any)
    logic [31:0] rows [7] = '{32'h6000_0001, 32'h4000_0000, 32'h4002_00AF, 32'h4002_0201,
        32'h4002_0100, 32'h8000_00AF, 32'h2000_005F};
    ocd_top dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .internal_oscillator(osc), .ext_clk_in(ext),
        .chip_sync(sync), .pair_a_output_first(pa0), .pair_a_output_second(pa1),
        .pair_b_output_first(pb0), .pair_b_output_second(pb1));
    // =========================================================
    // Tasks
    task automatic end_of_test;
        if (num_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic tmo;
        num_errors++;
        $display("ERROR %0t: wait ran out", $time);
        end_of_test;
    endtask
    task automatic rdy;
        int i;
        @(posedge clk);
        for (i = 0; i < 20 && hreadyout !== 1'b1; i++) @(posedge clk);
        if (i == 20) tmo;
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= a;
        rdy;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rdy;
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        check(q, e);
    endtask
    task automatic run(input int d, output int n, output logic lv);
        logic p;
        n = 0;
        p = d ? pb0 : pa0;
        repeat (10) begin
            @(negedge clk);
            lv = d ? pb0 : pa0;
            check(32'(d ? pb1 : pa1), 32'(lv));
            n += int'(lv !== p);
            p = lv;
        end
    endtask
    // Length of the next stretch of pair a at level lv, in clocks
    task automatic span(input logic lv, output int n);
        int i;
        n = 0;
        for (i = 0; i < 200 && pa0 !== lv; i++) @(negedge clk);
        if (i == 200) tmo;
        while (pa0 === lv && n < 200) begin
            @(negedge clk);
            n++;
        end
    endtask
    // Sync starts on a fixed tick phase so offsets compare cleanly
    task automatic pulse;
        @(posedge clk);
        if (ext === 1'b1) @(posedge clk);
        sync <= 1'b1;
        repeat (6) @(posedge clk);
        sync <= 1'b0;
    endtask
    // =========================================================
    // Clock, tick source and main sequence
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) ext <= ~ext;
    initial begin
        {rst_n, hsel, hwrite, ext, sync, htrans} = 7'h00;
        {haddr, hwdata} = 64'h0000_0000_0000_0000;
        hsize = ocd_pkg::HSIZE_WORD;
        osc = 1'b1;
        num_errors = 0;
        n_compared = 0;
        repeat (8) @(posedge clk);
        // Ready stays high through reset; pins, response and read data are low
        check(32'({pa0, pa1, pb0, pb1, hreadyout, hresp}), 32'h0000_0002);
        check(hrdata, 32'h0000_0000);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) rdc(BASE + 4 * i, 32'h0000_0000);
        rdc(PSEL, 32'h0000_0000);
        for (int d = 0; d < 2; d++) begin
            for (int r = 0; r < 7; r++) begin
                wr(BASE + 12 * d, 32'h0000_0000);
                wr(BASE + 12 * d + 4, 32'(rows[r][31:24]));
                wr(BASE + 12 * d + 8, 32'(rows[r][23:16]));
                wr(PSEL, 32'(rows[r][15:8]));
                repeat (4) @(posedge clk);
                run(d, t0, v);
                check(32'(t0), 32'(rows[r][7:4]));
                if (rows[r][3:0] != 4'hF) check(32'(v), 32'(rows[r][3:0]));
            end
        end
        for (int i = 0; i < 6; i++) begin
            wr(BASE + 4 * i, 32'hFFFF_FF00 | (32'h0000_003C + i));
            rdc(BASE + 4 * i, 32'h0000_003C + i);
        end
        wr(32'h0000_1640, 32'h0000_00FF);
        rdc(32'h0000_1640, 32'h0000_0000);
        rdc(BASE, 32'h0000_003C);
        wr(BASE + 4, 32'h0000_0000);
        wr(PSEL, 32'h0000_0000);
        for (int k = 0; k < 2; k++) begin
            wr(BASE + 8, 32'(1 - k));
            wr(BASE, k ? 32'h0000_0013 : 32'h0000_0023);
            repeat (2) span(1'b1, h);
            span(1'b0, l);
            check(32'(h), k ? 32'h0000_0004 : 32'h0000_0006);
            check(32'(l), 32'h0000_0004);
        end
        wr(BASE, 32'h0000_0033);
        for (int s = 0; s < 2; s++) begin
            wr(BASE + 4, 32'(s) << 4);
            pulse;
            @(negedge clk);
            check(32'(pa0), 32'(s));
        end
        for (int k = 0; k < 2; k++) begin
            wr(BASE + 4, 32'(3 * k));
            pulse;
            for (t1 = 0; t1 < 100 && pa0 !== 1'b1; t1++) @(negedge clk);
            if (t1 == 100) tmo;
            if (k == 0) t0 = t1;
        end
        check(32'(t1 - t0), 32'h0000_0006);
        // Ignored sync leaves the phase wait idle; obeyed sync with an offset enters it
        for (int k = 0; k < 2; k++) begin
            wr(BASE + 4, k ? 32'h0000_000F : 32'h0000_004F);
            sync <= 1'b1;
            repeat (2) @(posedge clk);
            rdc(STAT, k ? 32'h0000_0004 : 32'h0000_0000);
            sync <= 1'b0;
        end
        end_of_test;
    end
endmodule // output_channel_clock_divider_test
`default_nettype wire
